// *** core/status_event_summary.sv ***
/*
 * status_event_summary: standard event, operation and questionable status
 * groups behind a text-command port, with the summary status byte.
 * Assumes the command parser hands over one decoded command per cycle and
 * formats the binary answer as a decimal sum of bit weights.
 */
// Contract
// - standard event query returns the sum of set bits as binary weights.
// - writable standard enable mask; masked standard events drive status bit 5.
// - standard enable mask reads back the last written value.
// - status bit 7 is OR of operation events ANDed with their enables.
// - operation condition bits 0,3,4,5: IQ cal, sweep, bit error test, trigger wait.
// - bits 9..12: FM zero cal, waveform playback, pre-sweep, channel framing.
// - operation condition is 16 bits; unused bits always read zero.
// - operation condition tracks live activity, unlatched, read-only.
// - positive filter bit set: rising condition sets the event bit.
// - negative filter bit set: falling condition sets event; filters are writable.
// - operation event bits stay set after the condition returns.
// - reading an event register returns it and clears it.
// - operation enable mask writable and reads back the last written value.
// - questionable group has full filter path; its summary drives status bit 3.
// - latched event bits clear only on read or clear-status command.
// - standard event bits set directly by events, no transition filters.
`timescale 1ns/1ps
`default_nettype none

module status_event_summary
	import status_event_pkg::*;
(
	input  wire logic                   clk_i,
	input  wire logic                   srst_i,
	input  wire logic                   cmd_valid_i,
	input  wire cmd_req_t               cmd_i,
	input  wire activity_t              activity_i,
	input  wire logic [GROUP_WIDTH-1:0] ques_cond_i,
	input  wire logic [STD_WIDTH-1:0]   std_event_i,
	output logic                        resp_valid_o,
	output logic      [GROUP_WIDTH-1:0] resp_data_o,
	output logic      [STD_WIDTH-1:0]   status_byte_o
);

	function automatic logic hit(input logic v, input cmd_req_t c, input cmd_t t);
		return v && (c.code == t);
	endfunction : hit

	function automatic logic is_query(input cmd_t t);
		case (t)
			CMD_STD_EVT_Q, CMD_STD_EN_Q, CMD_OPER_COND_Q, CMD_OPER_EVT_Q,
			CMD_OPER_PTR_Q, CMD_OPER_NTR_Q, CMD_OPER_EN_Q, CMD_QUES_COND_Q,
			CMD_QUES_EVT_Q, CMD_QUES_PTR_Q, CMD_QUES_NTR_Q, CMD_QUES_EN_Q:
				return 1'b1;
			default:
				return 1'b0;
		endcase
	endfunction : is_query

	// activity levels come from other logic; two flops before use
	activity_t              act_meta;
	activity_t              act_sync;
	logic [GROUP_WIDTH-1:0] ques_meta;
	logic [GROUP_WIDTH-1:0] ques_sync;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			act_meta  <= '0;
			act_sync  <= '0;
			ques_meta <= '0;
			ques_sync <= '0;
		end else begin
			act_meta  <= activity_i;
			act_sync  <= act_meta;
			ques_meta <= ques_cond_i;
			ques_sync <= ques_meta;
		end
	end

	logic [GROUP_WIDTH-1:0] oper_cond;

	always_comb begin
		oper_cond                        = '0;
		oper_cond[OPER_IQ_CAL_BIT]       = act_sync.iq_cal;
		oper_cond[OPER_SWEEP_BIT]        = act_sync.sweep;
		oper_cond[OPER_BERT_BIT]         = act_sync.bert;
		oper_cond[OPER_WAIT_TRIG_BIT]    = act_sync.wait_trigger;
		oper_cond[OPER_FM_ZERO_CAL_BIT]  = act_sync.dc_freq_mod_zero_cal;
		oper_cond[OPER_WAVE_PLAY_BIT]    = act_sync.waveform_playback;
		oper_cond[OPER_PRE_SWEEP_BIT]    = act_sync.pre_sweep_calc;
		oper_cond[OPER_CHAN_FRAMING_BIT] = act_sync.channel_framing;
	end

	logic cls;
	assign cls = hit(cmd_valid_i, cmd_i, CMD_CLEAR_STATUS);

	logic [GROUP_WIDTH-1:0] oper_ptr;
	logic [GROUP_WIDTH-1:0] oper_ntr;
	logic [GROUP_WIDTH-1:0] oper_enable;
	logic [GROUP_WIDTH-1:0] oper_event;
	logic                   oper_summary;
	logic [GROUP_WIDTH-1:0] ques_ptr;
	logic [GROUP_WIDTH-1:0] ques_ntr;
	logic [GROUP_WIDTH-1:0] ques_enable;
	logic [GROUP_WIDTH-1:0] ques_event;
	logic                   ques_summary;

	status_group #(
		.WIDTH(GROUP_WIDTH)
	) u_oper (
		.clk_i      (clk_i),
		.srst_i     (srst_i),
		.cond_i     (oper_cond),
		.wr_data_i  (cmd_i.data),
		.wr_ptr_i   (hit(cmd_valid_i, cmd_i, CMD_OPER_PTR_W)),
		.wr_ntr_i   (hit(cmd_valid_i, cmd_i, CMD_OPER_NTR_W)),
		.wr_enable_i(hit(cmd_valid_i, cmd_i, CMD_OPER_EN_W)),
		.rd_event_i (hit(cmd_valid_i, cmd_i, CMD_OPER_EVT_Q)),
		.cls_i      (cls),
		.ptr_o      (oper_ptr),
		.ntr_o      (oper_ntr),
		.enable_o   (oper_enable),
		.event_o    (oper_event),
		.summary_o  (oper_summary)
	);

	status_group #(
		.WIDTH(GROUP_WIDTH)
	) u_ques (
		.clk_i      (clk_i),
		.srst_i     (srst_i),
		.cond_i     (ques_sync),
		.wr_data_i  (cmd_i.data),
		.wr_ptr_i   (hit(cmd_valid_i, cmd_i, CMD_QUES_PTR_W)),
		.wr_ntr_i   (hit(cmd_valid_i, cmd_i, CMD_QUES_NTR_W)),
		.wr_enable_i(hit(cmd_valid_i, cmd_i, CMD_QUES_EN_W)),
		.rd_event_i (hit(cmd_valid_i, cmd_i, CMD_QUES_EVT_Q)),
		.cls_i      (cls),
		.ptr_o      (ques_ptr),
		.ntr_o      (ques_ntr),
		.enable_o   (ques_enable),
		.event_o    (ques_event),
		.summary_o  (ques_summary)
	);

	// standard event group: no filters, events set bits directly
	logic [STD_WIDTH-1:0]   std_event;
	logic [STD_WIDTH-1:0]   std_enable;
	logic [STD_WIDTH-1:0]   next_std_event;
	logic [STD_WIDTH-1:0]   next_std_enable;
	logic [STD_WIDTH-1:0]   std_set;
	logic                   std_summary;
	logic                   next_std_summary;
	logic                   next_resp_valid;
	logic [GROUP_WIDTH-1:0] next_resp_data;

	always_comb begin
		std_set                   = std_event_i;
		std_set[STD_REQ_CTRL_BIT] = 1'b0;
		// set wins over a read or clear in the same cycle
		next_std_event = ((hit(cmd_valid_i, cmd_i, CMD_STD_EVT_Q) || cls) ? '0 : std_event)
		               | std_set;
		next_std_enable = hit(cmd_valid_i, cmd_i, CMD_STD_EN_W)
		                ? cmd_i.data[STD_WIDTH-1:0] : std_enable;
		next_std_summary = |(next_std_event & next_std_enable);
	end

	// answers are binary; the text layer prints them as decimal sums
	always_comb begin
		next_resp_valid = cmd_valid_i && is_query(cmd_i.code);
		case (cmd_i.code)
			CMD_STD_EVT_Q:   next_resp_data = {8'h00, std_event};
			CMD_STD_EN_Q:    next_resp_data = {8'h00, std_enable};
			CMD_OPER_COND_Q: next_resp_data = oper_cond;
			CMD_OPER_EVT_Q:  next_resp_data = oper_event;
			CMD_OPER_PTR_Q:  next_resp_data = oper_ptr;
			CMD_OPER_NTR_Q:  next_resp_data = oper_ntr;
			CMD_OPER_EN_Q:   next_resp_data = oper_enable;
			CMD_QUES_COND_Q: next_resp_data = ques_sync;
			CMD_QUES_EVT_Q:  next_resp_data = ques_event;
			CMD_QUES_PTR_Q:  next_resp_data = ques_ptr;
			CMD_QUES_NTR_Q:  next_resp_data = ques_ntr;
			CMD_QUES_EN_Q:   next_resp_data = ques_enable;
			default:         next_resp_data = '0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			std_event    <= STD_RESET;
			std_enable   <= STD_RESET;
			std_summary  <= 1'b0;
			resp_valid_o <= 1'b0;
			resp_data_o  <= '0;
		end else begin
			std_event    <= next_std_event;
			std_enable   <= next_std_enable;
			std_summary  <= next_std_summary;
			resp_valid_o <= next_resp_valid;
			resp_data_o  <= next_resp_data;
		end
	end

	// bits outside the three summaries belong to other logic
	always_comb begin
		status_byte_o              = '0;
		status_byte_o[SB_QUES_BIT] = ques_summary;
		status_byte_o[SB_STD_BIT]  = std_summary;
		status_byte_o[SB_OPER_BIT] = oper_summary;
	end

endmodule : status_event_summary

`default_nettype wire

// *** pkg/status_event_pkg.sv ***
/*
 * status_event_pkg: command codes, bit positions, reset values and carrier
 * structs shared by the status reporting core and its transition group.
 * Assumes a single clock domain at 100 MHz and a synchronous reset.
 */
package status_event_pkg;

	localparam int GROUP_WIDTH = 16;
	localparam int STD_WIDTH   = 8;

	// summary positions inside the status byte
	localparam int SB_QUES_BIT = 3;
	localparam int SB_STD_BIT  = 5;
	localparam int SB_OPER_BIT = 7;

	// operation condition positions
	localparam int OPER_IQ_CAL_BIT       = 0;
	localparam int OPER_SWEEP_BIT        = 3;
	localparam int OPER_BERT_BIT         = 4;
	localparam int OPER_WAIT_TRIG_BIT    = 5;
	localparam int OPER_FM_ZERO_CAL_BIT  = 9;
	localparam int OPER_WAVE_PLAY_BIT    = 10;
	localparam int OPER_PRE_SWEEP_BIT    = 11;
	localparam int OPER_CHAN_FRAMING_BIT = 12;

	// standard event bit that never sets (no control request)
	localparam int STD_REQ_CTRL_BIT = 1;

	// reset values
	localparam logic [GROUP_WIDTH-1:0] PTR_RESET    = 16'hFFFF;
	localparam logic [GROUP_WIDTH-1:0] NTR_RESET    = 16'h0000;
	localparam logic [GROUP_WIDTH-1:0] ENABLE_RESET = 16'h0000;
	localparam logic [GROUP_WIDTH-1:0] EVENT_RESET  = 16'h0000;
	localparam logic [STD_WIDTH-1:0]   STD_RESET    = 8'h00;

	typedef enum logic [4:0] {
		CMD_NONE,
		CMD_STD_EVT_Q,
		CMD_STD_EN_W,
		CMD_STD_EN_Q,
		CMD_OPER_COND_Q,
		CMD_OPER_EVT_Q,
		CMD_OPER_PTR_W,
		CMD_OPER_PTR_Q,
		CMD_OPER_NTR_W,
		CMD_OPER_NTR_Q,
		CMD_OPER_EN_W,
		CMD_OPER_EN_Q,
		CMD_QUES_COND_Q,
		CMD_QUES_EVT_Q,
		CMD_QUES_PTR_W,
		CMD_QUES_PTR_Q,
		CMD_QUES_NTR_W,
		CMD_QUES_NTR_Q,
		CMD_QUES_EN_W,
		CMD_QUES_EN_Q,
		CMD_CLEAR_STATUS
	} cmd_t;

	typedef struct packed {
		cmd_t                   code;
		logic [GROUP_WIDTH-1:0] data;
	} cmd_req_t;

	typedef struct packed {
		logic iq_cal;
		logic sweep;
		logic bert;
		logic wait_trigger;
		logic dc_freq_mod_zero_cal;
		logic waveform_playback;
		logic pre_sweep_calc;
		logic channel_framing;
	} activity_t;

endpackage : status_event_pkg

// *** core/status_group.sv ***
/*
 * status_group: condition edge filters, latched event bits, enable mask
 * and masked summary for one status group.
 * Assumes cond_i is already synchronous to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module status_group
	import status_event_pkg::*;
#(
	parameter int WIDTH = GROUP_WIDTH
) (
	input  wire logic             clk_i,
	input  wire logic             srst_i,
	input  wire logic [WIDTH-1:0] cond_i,
	input  wire logic [WIDTH-1:0] wr_data_i,
	input  wire logic             wr_ptr_i,
	input  wire logic             wr_ntr_i,
	input  wire logic             wr_enable_i,
	input  wire logic             rd_event_i,
	input  wire logic             cls_i,
	output logic      [WIDTH-1:0] ptr_o,
	output logic      [WIDTH-1:0] ntr_o,
	output logic      [WIDTH-1:0] enable_o,
	output logic      [WIDTH-1:0] event_o,
	output logic                  summary_o
);

	// refused at elaboration: reset constants are only GROUP_WIDTH bits wide
	if (WIDTH < 1 || WIDTH > GROUP_WIDTH) begin : g_width_check
		$error("status_group: WIDTH out of range");
	end

	logic [WIDTH-1:0] cond_prev;
	logic [WIDTH-1:0] next_ptr;
	logic [WIDTH-1:0] next_ntr;
	logic [WIDTH-1:0] next_enable;
	logic [WIDTH-1:0] next_event;
	logic [WIDTH-1:0] set_bits;
	logic             next_summary;

	always_comb begin
		set_bits    = (ptr_o & cond_i & ~cond_prev)
		            | (ntr_o & ~cond_i & cond_prev);
		next_ptr    = wr_ptr_i ? wr_data_i : ptr_o;
		next_ntr    = wr_ntr_i ? wr_data_i : ntr_o;
		next_enable = wr_enable_i ? wr_data_i : enable_o;
		// a new edge in the clearing cycle survives the clear
		next_event  = ((rd_event_i || cls_i) ? '0 : event_o) | set_bits;
		next_summary = |(next_event & next_enable);
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ptr_o     <= PTR_RESET[WIDTH-1:0];
			ntr_o     <= NTR_RESET[WIDTH-1:0];
			enable_o  <= ENABLE_RESET[WIDTH-1:0];
			event_o   <= EVENT_RESET[WIDTH-1:0];
			cond_prev <= '0;
			summary_o <= 1'b0;
		end else begin
			ptr_o     <= next_ptr;
			ntr_o     <= next_ntr;
			enable_o  <= next_enable;
			event_o   <= next_event;
			cond_prev <= cond_i;
			summary_o <= next_summary;
		end
	end

endmodule : status_group

`default_nettype wire

// *** bench/host_cmd_model.sv ***
/*
 * host_cmd_model: remote controller side, hands decoded commands to the core.
 * Assumes every task is entered in the time step of a rising clock edge.
 */
`timescale 1ns/1ps
`default_nettype none

module host_cmd_model
	import status_event_pkg::*;
(
	input  wire logic clk_i,
	output var  logic     cmd_valid_o,
	output var  cmd_req_t cmd_o
);
	initial begin
		cmd_valid_o = 1'b0;
		cmd_o = '{CMD_NONE, 16'h0000};
	end

	// valid stays high on return, so a further call goes back to back
	task automatic issue(input cmd_t code, input logic [GROUP_WIDTH-1:0] data);
		cmd_valid_o <= 1'b1;
		cmd_o <= '{code, data};
		@(posedge clk_i);
	endtask : issue

	// idle data is inverted, never left showing the last command
	task automatic stop();
		cmd_valid_o <= 1'b0;
		cmd_o <= '{CMD_NONE, ~cmd_o.data};
	endtask : stop
endmodule : host_cmd_model

`default_nettype wire

// *** bench/status_event_summary_checker.sv ***
/*
 * status_event_summary_checker: port-level assertions for the status core.
 * Assumes it is bound to status_event_summary; one clock, sync reset.
 */
`timescale 1ns/1ps
`default_nettype none

module status_event_summary_checker
	import status_event_pkg::*;
(
	input wire logic                   clk_i,
	input wire logic                   srst_i,
	input wire logic                   cmd_valid_i,
	input wire cmd_req_t               cmd_i,
	input wire activity_t              activity_i,
	input wire logic [GROUP_WIDTH-1:0] ques_cond_i,
	input wire logic [STD_WIDTH-1:0]   std_event_i,
	input wire logic                   resp_valid_o,
	input wire logic [GROUP_WIDTH-1:0] resp_data_o,
	input wire logic [STD_WIDTH-1:0]   status_byte_o
);
	logic is_q;
	logic oev_q;
	assign is_q = cmd_valid_i && cmd_i.code inside {CMD_STD_EVT_Q, CMD_STD_EN_Q,
		CMD_OPER_COND_Q, CMD_OPER_EVT_Q, CMD_OPER_PTR_Q, CMD_OPER_NTR_Q, CMD_OPER_EN_Q,
		CMD_QUES_COND_Q, CMD_QUES_EVT_Q, CMD_QUES_PTR_Q, CMD_QUES_NTR_Q, CMD_QUES_EN_Q};
	assign oev_q = cmd_valid_i && cmd_i.code == CMD_OPER_EVT_Q;

	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);

	AST_RESP_ONE: assert property (is_q |=> resp_valid_o)
		else $error("query not answered");
	AST_RESP_CAUSE: assert property (resp_valid_o |-> $past(is_q))
		else $error("answer without query");
	AST_SB_UNUSED: assert property ((status_byte_o & 8'h57) == 8'h00)
		else $error("unused status bit set");
	AST_STD_RISE: assert property ($rose(status_byte_o[SB_STD_BIT]) |->
		$past(std_event_i) != 8'h00 || $past(cmd_i.code) == CMD_STD_EN_W)
		else $error("standard summary rose without cause");
	AST_COND_ZERO: assert property (cmd_valid_i && cmd_i.code == CMD_OPER_COND_Q |=>
		(resp_data_o & 16'hE1C6) == 16'h0000)
		else $error("unused condition bit set");
	AST_EN_READBACK: assert property (cmd_valid_i && cmd_i.code == CMD_STD_EN_W ##1
		cmd_valid_i && cmd_i.code == CMD_STD_EN_Q |=>
		resp_data_o == {8'h00, $past(cmd_i.data[7:0], 2)})
		else $error("enable readback differs");
	AST_EVT_CLEAR: assert property ($stable(activity_i)[*4] ##0 oev_q ##1
		(oev_q && $stable(activity_i)) |=> resp_data_o == 16'h0000)
		else $error("event not cleared by read");
	AST_CLS_CLEAR: assert property (cmd_valid_i && cmd_i.code == CMD_CLEAR_STATUS &&
		(std_event_i & 8'hFD) == 8'h00 |=> !status_byte_o[SB_STD_BIT])
		else $error("clear status left summary");

	COV_STD: cover property (status_byte_o[SB_STD_BIT]);
	COV_OPER: cover property (status_byte_o[SB_OPER_BIT]);
	COV_QUES: cover property (status_byte_o[SB_QUES_BIT]);
endmodule : status_event_summary_checker

bind status_event_summary status_event_summary_checker chk_u (.clk_i, .srst_i,
	.cmd_valid_i, .cmd_i, .activity_i, .ques_cond_i, .std_event_i, .resp_valid_o,
	.resp_data_o, .status_byte_o);

`default_nettype wire

// *** bench/tb.sv ***
/*
 * tb: directed bench for status_event_summary driven through host_cmd_model.
 * Assumes the checker binds itself to the core.
 */
`timescale 1ns/1ps
`default_nettype none

module tb
	import status_event_pkg::*;
();
	logic clk_i;
	logic srst_i;
	logic cmd_valid;
	cmd_req_t cmd;
	activity_t activity;
	logic [15:0] ques_cond;
	logic [7:0] std_event;
	logic resp_valid;
	logic [15:0] resp_data;
	logic [7:0] status_byte;
	int err_total = 0;
	int checks = 0;
	int cycles = 0;
	// activity bit k, struct msb first, lands on this condition position
	int pos[8] = '{12, 11, 10, 9, 5, 4, 3, 0};

	status_event_summary dut (.clk_i(clk_i), .srst_i(srst_i), .cmd_valid_i(cmd_valid),
		.cmd_i(cmd), .activity_i(activity), .ques_cond_i(ques_cond), .std_event_i(std_event),
		.resp_valid_o(resp_valid), .resp_data_o(resp_data), .status_byte_o(status_byte));
	host_cmd_model host (.clk_i(clk_i), .cmd_valid_o(cmd_valid), .cmd_o(cmd));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : complete_run

	// run needs about 130 cycles
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 2000) begin
			err_total++;
			complete_run();
		end
	end

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		checks++;
		if (s !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic q(input cmd_t c, input logic [15:0] e);
		host.issue(c, 16'h0000);
		host.stop();
		#1;
		chk("resp_valid", 16'h0001, {15'h0000, resp_valid});
		chk(c.name(), e, resp_data);
		@(posedge clk_i);
	endtask : q

	// back-to-back pair: the first answer stands for one cycle only
	task automatic qq(input cmd_t c, input logic [15:0] e1, input logic [15:0] e2);
		fork
			begin
				host.issue(c, 16'h0000);
				host.issue(c, 16'h0000);
			end
			begin
				@(posedge clk_i);
				#1;
				chk("resp_valid", 16'h0001, {15'h0000, resp_valid});
				chk(c.name(), e1, resp_data);
			end
		join
		host.stop();
		#1;
		chk("resp_valid", 16'h0001, {15'h0000, resp_valid});
		chk(c.name(), e2, resp_data);
		@(posedge clk_i);
	endtask : qq

	task automatic sb(input logic [7:0] e);
		#1;
		chk("status_byte", {8'h00, e}, {8'h00, status_byte});
		@(posedge clk_i);
	endtask : sb

	task automatic pulse(input logic [7:0] e);
		std_event <= e;
		@(posedge clk_i);
		std_event <= 8'h00;
	endtask : pulse

	initial begin
		srst_i = 1'b1;
		activity = '0;
		ques_cond = 16'h0000;
		std_event = 8'h00;
		repeat (6) @(posedge clk_i);
		srst_i <= 1'b0;
		@(posedge clk_i);
		q(CMD_OPER_PTR_Q, 16'hFFFF);
		q(CMD_OPER_NTR_Q, 16'h0000);
		q(CMD_OPER_EN_Q, 16'h0000);
		q(CMD_QUES_PTR_Q, 16'hFFFF);
		q(CMD_QUES_NTR_Q, 16'h0000);
		q(CMD_STD_EN_Q, 16'h0000);
		$display("test reset values done");
		host.issue(CMD_STD_EN_W, 16'h00C0);
		q(CMD_STD_EN_Q, 16'h00C0);
		pulse(8'h03);
		sb(8'h00);
		pulse(8'h80);
		sb(8'h20);
		q(CMD_STD_EVT_Q, 16'h0081);
		q(CMD_STD_EVT_Q, 16'h0000);
		$display("test standard group done");
		for (int k = 0; k < 8; k++) begin
			activity <= activity_t'(8'h01 << k);
			repeat (4) @(posedge clk_i);
			q(CMD_OPER_COND_Q, 16'h0001 << pos[k]);
		end
		qq(CMD_OPER_EVT_Q, 16'h1E39, 16'h0000);
		host.issue(CMD_OPER_PTR_W, 16'h0000);
		host.issue(CMD_OPER_NTR_W, 16'h0001);
		q(CMD_OPER_NTR_Q, 16'h0001);
		q(CMD_OPER_PTR_Q, 16'h0000);
		activity <= activity_t'(8'h01);
		repeat (4) @(posedge clk_i);
		sb(8'h00);
		host.issue(CMD_OPER_EN_W, 16'h0001);
		host.stop();
		sb(8'h80);
		q(CMD_OPER_EN_Q, 16'h0001);
		q(CMD_OPER_EVT_Q, 16'h0001);
		sb(8'h00);
		$display("test operation group done");
		ques_cond <= 16'h0208;
		host.issue(CMD_QUES_EN_W, 16'h0200);
		host.stop();
		repeat (4) @(posedge clk_i);
		sb(8'h08);
		q(CMD_QUES_COND_Q, 16'h0208);
		q(CMD_QUES_EVT_Q, 16'h0208);
		sb(8'h00);
		host.issue(CMD_QUES_PTR_W, 16'h0008);
		host.issue(CMD_QUES_NTR_W, 16'h0200);
		q(CMD_QUES_PTR_Q, 16'h0008);
		q(CMD_QUES_NTR_Q, 16'h0200);
		q(CMD_QUES_EN_Q, 16'h0200);
		ques_cond <= 16'h0000;
		repeat (4) @(posedge clk_i);
		sb(8'h08);
		q(CMD_QUES_EVT_Q, 16'h0200);
		$display("test questionable group done");
		host.issue(CMD_STD_EN_W, 16'h0001);
		host.stop();
		pulse(8'h01);
		sb(8'h20);
		host.issue(CMD_CLEAR_STATUS, 16'h0000);
		host.stop();
		sb(8'h00);
		q(CMD_STD_EVT_Q, 16'h0000);
		$display("test clear status done");
		complete_run();
	end
endmodule : tb

`default_nettype wire
